// ==== verilog/brg_reset_gen.sv ====
// Summary of operation
// - Board goes into reset on power-up and on power-down per power-good input.
// - Pressing the manual reset button puts the board into reset.
// - A processor software reset instruction also asserts system reset.
// - Power-good rising with button open gives one 128 ms reset pulse.
// - Button closed then opened with power good gives 128 ms pulse from release.
// - Active-low reset stays low for the whole pulse, then goes high.
`timescale 1ns/1ps
`default_nettype none
module brg_reset_gen
  import brg_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic power_good_in,
  input  wire logic manual_reset_button,
  input  wire logic sw_reset_req,
  output var  logic system_reset_n,
  output var  logic pulse_active
);

  brg_cause_t             cause;
  brg_state_t             state_q;
  brg_state_t             state_d;
  logic       [CNT_W-1:0] cnt_q;
  logic       [CNT_W-1:0] cnt_d;
  logic                   rst_n_q;
  logic                   rst_n_d;
  logic                   busy_q;
  logic                   busy_d;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PULSE_LEN - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  assign cause.power_good = power_good_in;
  assign cause.button     = manual_reset_button;
  assign cause.sw_reset   = sw_reset_req;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      BRG_ST_HOLD: begin
        cnt_d = CNT_ZERO;
        // Power rising with button open starts the pulse
        if (cause.power_good && !cause.button) begin
          state_d = BRG_ST_PULSE;
        end
      end
      BRG_ST_BUTTON: begin
        cnt_d = CNT_ZERO;
        if (!cause.power_good) begin
          state_d = BRG_ST_HOLD;
        end else if (!cause.button) begin
          state_d = BRG_ST_PULSE;
        end
      end
      BRG_ST_PULSE: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_LAST) begin
          state_d = BRG_ST_RUN;
        end
      end
      BRG_ST_RUN: begin
        cnt_d = CNT_ZERO;
      end
      default: begin
        state_d = BRG_ST_HOLD;
        cnt_d   = CNT_ZERO;
      end
    endcase
    // Qualifying events override everything, restarting the count
    if (!cause.power_good) begin
      state_d = BRG_ST_HOLD;
      cnt_d   = CNT_ZERO;
    end else if (cause.button) begin
      state_d = BRG_ST_BUTTON;
      cnt_d   = CNT_ZERO;
    end else if (cause.sw_reset) begin
      state_d = BRG_ST_PULSE;
      cnt_d   = CNT_ZERO;
    end
    rst_n_d = (state_d == BRG_ST_RUN);
    busy_d  = (state_d == BRG_ST_PULSE);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= BRG_ST_HOLD;
      cnt_q   <= CNT_ZERO;
      rst_n_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rst_n_q <= rst_n_d;
      busy_q  <= busy_d;
    end
  end

  assign system_reset_n = rst_n_q;
  assign pulse_active   = busy_q;

endmodule : brg_reset_gen
`default_nettype wire

// ==== verilog/brg_pkg.sv ====
package brg_pkg;

  // Clock and pulse timing
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned PULSE_MS        = 128;
  localparam longint unsigned PULSE_CYC_L = (longint'(CLK_HZ) * PULSE_MS) / 1000;
  localparam int unsigned PULSE_CYCLES    = int'(PULSE_CYC_L);
  localparam int unsigned CNT_W           = 25;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    BRG_ST_HOLD   = 4'h1,
    BRG_ST_BUTTON = 4'h2,
    BRG_ST_PULSE  = 4'h4,
    BRG_ST_RUN    = 4'h8
  } brg_state_t;

  // Inputs that may call for a reset
  typedef struct packed {
    logic power_good;
    logic button;
    logic sw_reset;
  } brg_cause_t;

endpackage : brg_pkg

// ==== bench/brg_reset_gen_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module brg_reset_gen_sva #(parameter int unsigned PULSE_LEN = 16) (
  input wire logic clk, srst, power_good_in, manual_reset_button,
  input wire logic sw_reset_req, system_reset_n, pulse_active);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_power_low_hold: assert property (!power_good_in |=> !system_reset_n) else $error("reset");
  a_button_hold: assert property (manual_reset_button |=> !system_reset_n) else $error("button");
  a_sw_reset: assert property (sw_reset_req |=> !system_reset_n) else $error("sw");
  a_power_up_pulse: assert property ($rose(power_good_in) && !manual_reset_button |=> pulse_active)
    else $error("power up");
  a_release_pulse: assert property ($fell(manual_reset_button) && power_good_in |=> pulse_active)
    else $error("release");
  a_low_in_pulse: assert property (pulse_active |-> !system_reset_n) else $error("pulse");
  a_pulse_length: assert property ($fell(pulse_active) && system_reset_n |-> $past(pulse_active, PULSE_LEN))
    else $error("length");
endmodule : brg_reset_gen_sva
bind brg_reset_gen brg_reset_gen_sva #(.PULSE_LEN(PULSE_LEN)) chk (.*);
`default_nettype wire

// ==== bench/brg_supply.sv ====
`timescale 1ns/1ps
`default_nettype none
module brg_supply (input wire logic clk, output var logic pg, output var logic btn);
  initial begin pg = 0; btn = 0; end
  // Levels move only after an edge
  task automatic set(input logic p, input logic b); @(posedge clk) #1; pg = p; btn = b; endtask
endmodule : brg_supply
`default_nettype wire

// ==== bench/brg_reset_gen_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module brg_reset_gen_bench;
  logic clk = 0, srst = 1, sw = 0, pg, bt, rn, pa;
  int bad_count, n_compared, cyc;
  brg_supply sup (.clk(clk), .pg(pg), .btn(bt));
  brg_reset_gen #(.PULSE_LEN(16)) uut (.clk(clk), .srst(srst), .power_good_in(pg),
    .manual_reset_button(bt), .sw_reset_req(sw), .system_reset_n(rn), .pulse_active(pa));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [1:0] e); n_compared++;
    if ({rn, pa} !== e) begin bad_count++; $display("[FAIL] %0t %h %h", $time, {rn, pa}, e); end
  endtask : chk
  task automatic give_verdict; if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL"); $finish; endtask : give_verdict
  task automatic wt(int n); repeat (n) begin @(posedge clk); end #1; endtask : wt
  // Full pulse, 16 cycles
  task automatic pulse_ok; wt(1); sw = 0; chk(2'h1); wt(15); chk(2'h1); wt(1); chk(2'h2); endtask : pulse_ok
  always @(posedge clk) if (++cyc > 2000) begin bad_count++; give_verdict; end
  initial begin
    wt(6); srst = 0;
    sup.set(1, 0); pulse_ok;
    sup.set(1, 1); wt(20); chk(2'h0);
    sup.set(1, 0); pulse_ok;
    wt(3); sw = 1; pulse_ok;
    // Second request mid-pulse must restart the count
    wt(3); sw = 1; wt(1); sw = 0; wt(7); sw = 1; pulse_ok;
    sup.set(0, 0); wt(5); chk(2'h0);
    srst = 1; wt(2); chk(2'h0); srst = 0;
    sup.set(1, 0); pulse_ok;
    give_verdict;
  end
endmodule : brg_reset_gen_bench
`default_nettype wire
